/* File: hw/sbc_defs.vh */
// Behaviour
// - bring fpga a then fpga b out of init, then release cpu reset.
// - board info low two bits hold read-only board version; upper bits zero.
// - logic version: bit 6 released build flag, bits 5:0 revision, read-only.
// - read-only eight-bit logic sub-revision for hardware debug.
// - supply health bits 3/2 show supply 2/1 input good.
// - supply health bits 1/0 show supply 2/1 dc output good.
// - reset register a drives eight active-low resets, all reset to 1.
// - reset register b drives eight active-low resets, all reset to 1.
// - reset register c bits 1/0 reset fpga b/a, default 1; rest reserved.
// - event bit reads 0 after input change since last read; read restores 1 unless the input changes in the read cycle.
// - event register b: presences, pcie wake, trust irq, pcie irq, presence pin.
// - event register c: usb fault, 5v good, rails ok, supply input and output.
// - mask registers b and c hold one read-write bit per event, default 1.
// - logic image reload restarts outputs from reset: fpga and cpu resets asserted again.
// - live status registers report current input level, default 1.
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH
`define SBC_OFF_BOARD_INFO   8'h00
`define SBC_OFF_LOGIC_VER    8'h01
`define SBC_OFF_LOGIC_SUB    8'h02
`define SBC_OFF_SUPPLY       8'h03
`define SBC_OFF_RST_A        8'h05
`define SBC_OFF_RST_B        8'h06
`define SBC_OFF_RST_C        8'h07
`define SBC_OFF_EVT_A        8'h10
`define SBC_OFF_EVT_B        8'h11
`define SBC_OFF_EVT_C        8'h12
`define SBC_OFF_MASK_A       8'h20
`define SBC_OFF_MASK_B       8'h21
`define SBC_OFF_MASK_C       8'h22
`define SBC_OFF_LIVE_A       8'h30
`define SBC_OFF_LIVE_B       8'h31
`define SBC_OFF_LIVE_C       8'h32
`define SBC_RST_DEFAULT      8'hff
`define SBC_RST_C_MASK       8'h03
`define SBC_EVT_DEFAULT      8'hff
`define SBC_MASK_DEFAULT     8'hff
`define SBC_BOARD_VER_W      2
`define SBC_REL_BIT          6
`define SBC_REV_W            6
`define SBC_SEQ_GAP_NS       1000
`define SBC_CLK_NS           20
`define SBC_SEQ_GAP_CYC      ((`SBC_SEQ_GAP_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_SEQ_CNT_W        8
`endif

/* File: hw/sbc_sync.v */
`timescale 1ns/1ps
`include "sbc_defs.vh"
module sbc_sync
#(
  parameter W = 8
)
(
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  // level in and out
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage1;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= {W{1'b1}};
      dout   <= {W{1'b1}};
    end
    else if (ce)
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

/* File: hw/sbc_event.v */
`timescale 1ns/1ps
`include "sbc_defs.vh"
module sbc_event
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // synchronised levels
  input  wire [7:0] level,
  // read of this event register
  input  wire       rd_clear,
  // state
  output reg  [7:0] change_n,
  output reg  [7:0] last
);
  wire [7:0] changed = level ^ last;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      change_n <= `SBC_EVT_DEFAULT;
      last     <= `SBC_EVT_DEFAULT;
    end
    else if (ce)
    begin
      last <= level;
      // a change in the read cycle survives the clear
      if (rd_clear)
        change_n <= ~changed;
      else
        change_n <= change_n & ~changed;
    end
  end
endmodule

/* File: hw/sbc_top.v */
`timescale 1ns/1ps
`include "sbc_defs.vh"
module sbc_top
#(
  parameter [1:0] BOARD_VERSION = 2'h0,
  parameter       RELEASED      = 1'b0,
  parameter [5:0] LOGIC_REV     = 6'h01,
  parameter [7:0] LOGIC_SUB_REV = 8'h00
)
(
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  // register port from management controller's i2c front end
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // monitored pins
  input  wire [3:0] supply_pins,
  input  wire [7:0] event_pins_a,
  input  wire [7:0] event_pins_b,
  input  wire [7:0] event_pins_c,
  // fpga init done pins
  input  wire       fpga_a_done,
  input  wire       fpga_b_done,
  // reset outputs, active low
  output reg  [7:0] reset_a_n,
  output reg  [7:0] reset_b_n,
  output reg        fpga_a_reset_n,
  output reg        fpga_b_reset_n,
  output reg        cpu_reset_n,
  // aggregated interrupt, active low
  output reg        event_irq_n
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [3:0] sync_supply;
  wire [7:0] live_a;
  wire [7:0] live_b;
  wire [7:0] live_c;
  wire [1:0] sync_done_n;
  sbc_sync #(.W(4)) u_sync_sup (.clk(clk), .rst(rst), .ce(ce), .din(supply_pins), .dout(sync_supply));
  sbc_sync #(.W(8)) u_sync_a (.clk(clk), .rst(rst), .ce(ce), .din(event_pins_a), .dout(live_a));
  sbc_sync #(.W(8)) u_sync_b (.clk(clk), .rst(rst), .ce(ce), .din(event_pins_b), .dout(live_b));
  sbc_sync #(.W(8)) u_sync_c (.clk(clk), .rst(rst), .ce(ce), .din(event_pins_c), .dout(live_c));
  // done pins go in inverted: the synchroniser resets high, which must read as not done
  sbc_sync #(.W(2)) u_sync_d (.clk(clk), .rst(rst), .ce(ce), .din(~{fpga_b_done, fpga_a_done}),
                               .dout(sync_done_n));

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  wire rd_a = reg_rd && hit(reg_addr, `SBC_OFF_EVT_A);
  wire rd_b = reg_rd && hit(reg_addr, `SBC_OFF_EVT_B);
  wire rd_c = reg_rd && hit(reg_addr, `SBC_OFF_EVT_C);

  // ----------------------------------------
  // change-detect events
  // ----------------------------------------
  wire [7:0] evt_a;
  wire [7:0] evt_b;
  wire [7:0] evt_c;
  sbc_event u_evt_a (.clk(clk), .rst(rst), .ce(ce), .level(live_a), .rd_clear(rd_a), .change_n(evt_a),
                     .last());
  sbc_event u_evt_b (.clk(clk), .rst(rst), .ce(ce), .level(live_b), .rd_clear(rd_b), .change_n(evt_b),
                     .last());
  sbc_event u_evt_c (.clk(clk), .rst(rst), .ce(ce), .level(live_c), .rd_clear(rd_c), .change_n(evt_c),
                     .last());

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  reg [7:0] rst_a;
  reg [7:0] rst_b;
  reg [7:0] rst_c;
  reg [7:0] mask_a;
  reg [7:0] mask_b;
  reg [7:0] mask_c;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rst_a  <= `SBC_RST_DEFAULT;
      rst_b  <= `SBC_RST_DEFAULT;
      rst_c  <= `SBC_RST_C_MASK;
      mask_a <= `SBC_MASK_DEFAULT;
      mask_b <= `SBC_MASK_DEFAULT;
      mask_c <= `SBC_MASK_DEFAULT;
    end
    else if (ce && reg_wr)
    begin
      // writes elsewhere (read-only, reserved, unmapped) fall through
      case (reg_addr)
        `SBC_OFF_RST_A:  rst_a  <= reg_wdata;
        `SBC_OFF_RST_B:  rst_b  <= reg_wdata;
        `SBC_OFF_RST_C:  rst_c  <= reg_wdata & `SBC_RST_C_MASK;
        `SBC_OFF_MASK_A: mask_a <= reg_wdata;
        `SBC_OFF_MASK_B: mask_b <= reg_wdata;
        `SBC_OFF_MASK_C: mask_c <= reg_wdata;
        default:         rst_a  <= rst_a;
      endcase
    end
  end

  // ----------------------------------------
  // fpga bring-up sequence
  // ----------------------------------------
  // one-hot: both fpgas share a flash, so they must not load together
  localparam [4:0] S_INIT_A = 5'h01;
  localparam [4:0] S_GAP    = 5'h02;
  localparam [4:0] S_INIT_B = 5'h04;
  localparam [4:0] S_CPU    = 5'h08;
  localparam [4:0] S_RUN    = 5'h10;
  reg [4:0]                state;
  reg [4:0]                next_state;
  reg [`SBC_SEQ_CNT_W-1:0] gap_cnt;
  // load value for the gap counter, cut to the counter's width on purpose
  localparam [31:0]        GAP_LOAD = `SBC_SEQ_GAP_CYC - 1;
  always @*
  begin
    next_state = state;
    case (state)
      S_INIT_A: if (!sync_done_n[0]) next_state = S_GAP;
      S_GAP:    if (gap_cnt == `SBC_SEQ_CNT_W'd0) next_state = S_INIT_B;
      S_INIT_B: if (!sync_done_n[1]) next_state = S_CPU;
      S_CPU:    next_state = S_RUN;
      S_RUN:    next_state = S_RUN;
      default:  next_state = S_INIT_A;
    endcase
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state   <= S_INIT_A;
      gap_cnt <= `SBC_SEQ_CNT_W'd0;
    end
    else if (ce)
    begin
      state <= next_state;
      if (state == S_INIT_A)
        gap_cnt <= GAP_LOAD[`SBC_SEQ_CNT_W-1:0];
      else if (gap_cnt != `SBC_SEQ_CNT_W'd0)
        gap_cnt <= gap_cnt - `SBC_SEQ_CNT_W'd1;
    end
  end

  // ----------------------------------------
  // outputs, all registered
  // ----------------------------------------
  // outputs hold their reset values; a reloaded image starts from them, putting the fpgas and cpu back in reset
  wire       seq_b_go  = (state == S_INIT_B) || (state == S_CPU) || (state == S_RUN);
  wire [7:0] pend      = (~evt_a & ~mask_a) | (~evt_b & ~mask_b) | (~evt_c & ~mask_c);
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reset_a_n      <= `SBC_RST_DEFAULT;
      reset_b_n      <= `SBC_RST_DEFAULT;
      fpga_a_reset_n <= 1'b0;
      fpga_b_reset_n <= 1'b0;
      cpu_reset_n    <= 1'b0;
      event_irq_n    <= 1'b1;
    end
    else if (ce)
    begin
      reset_a_n      <= rst_a;
      reset_b_n      <= rst_b;
      fpga_a_reset_n <= rst_c[0];
      fpga_b_reset_n <= rst_c[1] & seq_b_go;
      cpu_reset_n    <= (state == S_RUN);
      event_irq_n    <= ~(|pend);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [7:0] next_rdata;
  always @*
  begin
    case (reg_addr)
      `SBC_OFF_BOARD_INFO: next_rdata = {6'h00, BOARD_VERSION};
      `SBC_OFF_LOGIC_VER:  next_rdata = {1'b0, RELEASED, LOGIC_REV};
      `SBC_OFF_LOGIC_SUB:  next_rdata = LOGIC_SUB_REV;
      `SBC_OFF_SUPPLY:     next_rdata = {4'h0, sync_supply};
      `SBC_OFF_RST_A:      next_rdata = rst_a;
      `SBC_OFF_RST_B:      next_rdata = rst_b;
      `SBC_OFF_RST_C:      next_rdata = rst_c & `SBC_RST_C_MASK;
      `SBC_OFF_EVT_A:      next_rdata = evt_a;
      `SBC_OFF_EVT_B:      next_rdata = evt_b;
      `SBC_OFF_EVT_C:      next_rdata = evt_c;
      `SBC_OFF_MASK_A:     next_rdata = mask_a;
      `SBC_OFF_MASK_B:     next_rdata = mask_b;
      `SBC_OFF_MASK_C:     next_rdata = mask_c;
      `SBC_OFF_LIVE_A:     next_rdata = live_a;
      `SBC_OFF_LIVE_B:     next_rdata = live_b;
      `SBC_OFF_LIVE_C:     next_rdata = live_c;
      default:             next_rdata = 8'h00;
    endcase
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (ce && reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule

/* File: test/sbc_top_asserts.sv */
`timescale 1ns/1ps
module sbc_chk
(
  // watched ports
  input wire       clk,
  input wire       rst,
  input wire       ce,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] reset_a_n,
  input wire       fpga_a_reset_n,
  input wire       fpga_b_reset_n,
  input wire       cpu_reset_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_unmapped_zero: assert property (ce && reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_board_upper: assert property (ce && reg_rd && reg_addr == 8'h00 |=> reg_rdata[7:2] == 6'h00)
    else $error("board info upper bits set");
  a_version_top: assert property (ce && reg_rd && reg_addr == 8'h01 |=> !reg_rdata[7])
    else $error("logic version bit 7 set");
  a_rstc_upper: assert property (ce && reg_rd && reg_addr == 8'h07 |=> reg_rdata[7:2] == 6'h00)
    else $error("reset c upper bits set");
  a_rsta_follow: assert property (ce && reg_wr && reg_addr == 8'h05 ##1 ce |=> reset_a_n == $past(reg_wdata, 2))
    else $error("reset a output not written value");
  a_seq_fpga: assert property ($rose(fpga_b_reset_n) |-> fpga_a_reset_n)
    else $error("fpga b released before fpga a");
  a_seq_cpu: assert property ($rose(cpu_reset_n) |-> fpga_a_reset_n && fpga_b_reset_n)
    else $error("cpu released before both fpgas");
  a_reset_dflt: assert property ($fell(rst) |-> reset_a_n == 8'hff && !cpu_reset_n)
    else $error("reset defaults wrong");
endmodule
bind sbc_top sbc_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reset_a_n(reset_a_n), .fpga_a_reset_n(fpga_a_reset_n),
  .fpga_b_reset_n(fpga_b_reset_n), .cpu_reset_n(cpu_reset_n));

/* File: test/sbc_bmc.sv */
`timescale 1ns/1ps
module sbc_bmc
(
  // register port toward the device
  input  wire        clk,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_wdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
  // idle lines show the inverse so stale values never look valid
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    @(posedge clk);
    #1;
    {reg_wr, reg_rd} = 2'b00;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

/* File: test/sbc_top_bench.sv */
`timescale 1ns/1ps
module sbc_top_bench;
  // ----
  // stimulus and bookkeeping
  // ----
  logic            clk = 0;
  logic            rst = 1;
  logic            ce = 1;
  logic            fa_d = 0;
  logic            fb_d = 0;
  logic            pend = 0;
  logic            fa_n, fb_n, cpu_n, irq_n, wr, rd;
  logic [2:0][7:0] ev;
  logic [3:0]      sup;
  logic [7:0]      rdata, ra_n, rb_n, addr, wdata, chg, d, i;
  logic [7:0]      exp_q [$];
  logic [7:0]      offs [13] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h20, 8'h21,
                                 8'h22, 8'h04};
  logic [7:0]      dflt [13] = '{8'h02, 8'h6a, 8'h5c, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                 8'hff, 8'h00};
  integer          failures = 0;
  integer          cmp_count = 0;
  integer          cyc = 0;
  integer          seed = 9703;
  always #10 clk = ~clk;
  sbc_top #(.BOARD_VERSION(2'h2), .RELEASED(1'b1), .LOGIC_REV(6'h2a), .LOGIC_SUB_REV(8'h5c)) u_dut
  (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
   .reg_rdata(rdata), .supply_pins(sup), .event_pins_a(ev[0]), .event_pins_b(ev[1]), .event_pins_c(ev[2]),
   .fpga_a_done(fa_d), .fpga_b_done(fb_d), .reset_a_n(ra_n), .reset_b_n(rb_n), .fpga_a_reset_n(fa_n),
   .fpga_b_reset_n(fb_n), .cpu_reset_n(cpu_n), .event_irq_n(irq_n));
  sbc_bmc u_bmc (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));
  task check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      failures++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_bmc.xfer(1'b0, a, 8'h00);
  endtask
  task wait_cyc(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // read data lands one edge after the strobe
  always @(posedge clk)
  begin
    if (pend)
      check(rdata, exp_q.pop_front());
    pend <= rd;
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict;
    end
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    // event pins rest high: every source is active low
    ev = 24'hffffff;
    sup = 4'($random(seed));
    wait_cyc(12);
    rst = 0;
    wait_cyc(1);
    check({5'h0, fa_n, fb_n, cpu_n}, 8'h04);
    for (i = 0; i < 13; i++)
      rdx(offs[i], dflt[i]);
    rdx(8'h03, {4'h0, sup});
    u_bmc.xfer(1'b1, 8'h01, 8'h00);
    u_bmc.xfer(1'b1, 8'h04, 8'h55);
    rdx(8'h01, 8'h6a);
    rdx(8'h04, 8'h00);
    fa_d = 1;
    wait_cyc(40);
    check({7'h0, fb_n}, 8'h00);
    wait_cyc(20);
    check({6'h0, fb_n, cpu_n}, 8'h02);
    fb_d = 1;
    wait_cyc(6);
    check({7'h0, cpu_n}, 8'h01);
    for (i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      u_bmc.xfer(1'b1, (i < 3) ? 8'h05 + i : 8'h1d + i, d);
      wait_cyc(1);
      if (i == 0)
        check(ra_n, d);
      if (i == 1)
        check(rb_n, d);
      if (i == 2)
        check({6'h0, fb_n, fa_n}, d & 8'h03);
      rdx((i < 3) ? 8'h05 + i : 8'h1d + i, (i == 2) ? d & 8'h03 : d);
    end
    u_bmc.xfer(1'b1, 8'h07, 8'h03);
    for (i = 0; i < 3; i++)
    begin
      u_bmc.xfer(1'b1, 8'h20 + i, 8'hff);
      chg = 8'($random(seed)) | 8'h01;
      ev[i] = ev[i] ^ chg;
      wait_cyc(6);
      check({7'h0, irq_n}, 8'h01);
      rdx(8'h10 + i, ~chg);
      rdx(8'h10 + i, 8'hff);
      rdx(8'h30 + i, ev[i]);
      u_bmc.xfer(1'b1, 8'h20 + i, ~chg);
      ev[i] = ev[i] ^ chg;
      wait_cyc(6);
      check({7'h0, irq_n}, 8'h00);
      rdx(8'h10 + i, ~chg);
      wait_cyc(4);
      check({7'h0, irq_n}, 8'h01);
    end
    sup = ~sup;
    wait_cyc(4);
    rdx(8'h03, {4'h0, sup});
    // frozen while ce is low, then the held-off change shows up
    ce = 0;
    ev[0] = ~ev[0];
    wait_cyc(8);
    check({7'h0, irq_n}, 8'h01);
    ce = 1;
    wait_cyc(6);
    check({7'h0, irq_n}, 8'h00);
    rdx(8'h10, 8'h00);
    wait_cyc(4);
    print_verdict;
  end
endmodule
